// ---- src/ssw_pkg.sv ----
// Package with constants and carrier types for the servo status word flags block
package ssw_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] MOTION_STATUS_FLAGS_REG = 8'h03;
   localparam int STATUS_WIDTH = 16;
   localparam int MASK_WIDTH = 15;
   localparam logic [15:0] STATUS_RESET = 16'h0000;
   localparam logic [14:0] MASK_RESET = 15'h0000;

   // ----------------------------------------
   // Bit positions
   // ----------------------------------------
   localparam int BIT_RESERVED = 15;
   localparam int BIT_LOW_VOLT = 14;
   localparam int BIT_OVER_VOLT = 13;
   localparam int BIT_WAIT_DONE = 12;
   localparam int BIT_INPUT_FOUND = 11;
   localparam int BIT_HALT_SEEN = 10;
   localparam int BIT_HOLD_ERR = 9;
   localparam int BIT_MOVE_ERR = 8;
   localparam int BIT_TEMP_OK = 7;
   localparam int BIT_IO3 = 6;
   localparam int BIT_IO2 = 5;
   localparam int BIT_IO1 = 4;
   localparam int BIT_CALC_NEG = 3;
   localparam int BIT_CALC_POS = 2;
   localparam int BIT_CALC_ZERO = 1;
   localparam int BIT_INDEX = 0;
   localparam int POLL_MASK_BIT = 6;

   // Latched bit set: 14..8 and 0
   localparam logic [15:0] LATCHED_BITS = 16'h7f01;

   // Decimal answer: five BCD digits cover 0..65535
   localparam int BCD_DIGITS = 5;

   // ----------------------------------------
   // Carrier types
   // ----------------------------------------
   // Hardware event pulses from the motion core
   typedef struct packed {
      logic low_volt;
      logic over_volt;
      logic wait_done;
      logic input_found;
      logic halt_seen;
      logic hold_err;
      logic move_err;
      logic index_found;
   } ssw_events_t;

   // Live conditions from the motion core
   typedef struct packed {
      logic over_temp;
      logic [2:0] io_line;
      logic calc_neg;
      logic calc_pos;
      logic calc_zero;
   } ssw_live_t;

   // Host command strobes
   typedef struct packed {
      logic read_status_cmd;
      logic clear_latched_status_cmd;
      logic status_check_mask_cmd;
   } ssw_cmd_t;
endpackage

// ---- src/ssw_bcd_conv.sv ----
// Binary to decimal converter for the status word answer
`timescale 1ns/1ps
module ssw_bcd_conv #(
   parameter int WIDTH = 16,
   parameter int DIGITS = 5
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Request
   input wire logic start,
   input wire logic [WIDTH-1:0] value,
   // Answer
   output logic busy,
   output logic done,
   output logic [4*DIGITS-1:0] bcd
);
   // Elaboration check: digits must hold the full binary range
   if (DIGITS * 10 < WIDTH * 3) begin : g_bad
      $error("ssw_bcd_conv: too few digits");
   end

   logic [WIDTH-1:0] shreg;
   logic [4*DIGITS-1:0] acc;
   logic [4*DIGITS-1:0] adj;
   logic [$clog2(WIDTH+1)-1:0] cnt;

   // Add three to every digit above four
   always_comb begin
      for (int d = 0; d < DIGITS; d++) begin
         adj[4*d +: 4] = (acc[4*d +: 4] > 4'h4) ? acc[4*d +: 4] + 4'h3 : acc[4*d +: 4];
      end
   end

   // Shift-and-add sequencer, one bit a cycle
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         shreg <= '0;
         acc <= '0;
         cnt <= '0;
         busy <= 1'b0;
         done <= 1'b0;
         bcd <= '0;
      end else begin
         done <= 1'b0;
         if (start && !busy) begin
            shreg <= value;
            acc <= '0;
            cnt <= ($clog2(WIDTH+1))'(WIDTH);
            busy <= 1'b1;
         end else if (busy) begin
            acc <= {adj[4*DIGITS-2:0], shreg[WIDTH-1]};
            shreg <= {shreg[WIDTH-2:0], 1'b0};
            cnt <= cnt - 1'b1;
            if (cnt == 1) begin
               busy <= 1'b0;
               done <= 1'b1;
               bcd <= {adj[4*DIGITS-2:0], shreg[WIDTH-1]};
            end
         end
      end
   end
endmodule // ssw_bcd_conv

// ---- src/ssw_status_word.sv ----
// Servo internal status word with latched flags, condition mask and poll bit
`timescale 1ns/1ps

// Operation
// [R1] Status word is upper half of register 3
// [R2] Bit 14 latches on low voltage error
// [R3] Bit 13 latches on over voltage error
// [R4] Bit 12 latches on wait delay expiry
// [R5] Bit 11 latches input stop, clears next move
// [R6] Bit 10 latches on halt motion command
// [R7] Bit 9 latches holding error limit exceeded
// [R8] Bit 8 latches moving error limit exceeded
// [R9] Bit 7 live temperature good indication
// [R10] Bits 6..4 show live I/O lines 3..1
// [R11] Bits 3..1 live negative, positive, zero result
// [R12] Bit 0 latches on encoder index found
// [R13] Clear command resets all latched bits together
// [R14] Live bits present; latched since last clear
// [R15] Read command answers word in decimal
// [R16] Fifteen-entry mask, host toggles each enable
// [R17] Poll bit 6 is OR of enabled conditions
// [R18] Motion stop conditions taken from word bits
// [R19] Bit 15 reads zero, no mask entry
module ssw_status_word #(
   parameter int STATUS_W = ssw_pkg::STATUS_WIDTH,
   parameter int MASK_W = ssw_pkg::MASK_WIDTH
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Event pulses and live conditions from the motion core
   input wire ssw_pkg::ssw_events_t events,
   input wire ssw_pkg::ssw_live_t live,
   input wire logic move_start,
   input wire logic holding_state,
   input wire logic moving_state,
   // Host command strobes and mask toggle selector
   input wire ssw_pkg::ssw_cmd_t cmd,
   input wire logic [14:0] mask_toggle,
   // Program data register port
   input wire logic [7:0] reg_addr,
   output logic [31:0] reg_rdata,
   // Stop condition select for motion commands
   input wire logic [15:0] stop_select,
   output logic stop_hit,
   // Host answers
   output logic [15:0] status_word,
   output logic [14:0] check_mask,
   output logic poll_status_bit,
   output logic answer_valid,
   output logic [19:0] answer_decimal
);
   // ----------------------------------------
   // Elaboration checks
   // ----------------------------------------
   if (STATUS_W != 16 || MASK_W != 15) begin : g_bad
      $error("ssw_status_word: only a 16-bit word with 15 mask entries is served");
   end

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // The I/O lines and the temperature sensor are asynchronous pins
   logic [3:0] pin_meta;
   logic [3:0] pin_sync;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_meta <= 4'h7;
         pin_sync <= 4'h7;
      end else begin
         pin_meta <= {live.over_temp, live.io_line};
         pin_sync <= pin_meta;
      end
   end

   wire sync_over_temp = pin_sync[3];
   wire [2:0] sync_io = pin_sync[2:0];

   // ----------------------------------------
   // Latched flags
   // ----------------------------------------
   logic [15:0] latched;
   logic [15:0] set_vec;
   logic [15:0] next_latched;

   // Event qualification; the holding and moving error bits depend on control state
   always_comb begin
      set_vec = '0;
      set_vec[ssw_pkg::BIT_LOW_VOLT] = events.low_volt; // see [R2]
      set_vec[ssw_pkg::BIT_OVER_VOLT] = events.over_volt; // see [R3]
      set_vec[ssw_pkg::BIT_WAIT_DONE] = events.wait_done; // see [R4]
      set_vec[ssw_pkg::BIT_INPUT_FOUND] = events.input_found; // see [R5]
      set_vec[ssw_pkg::BIT_HALT_SEEN] = events.halt_seen; // see [R6]
      set_vec[ssw_pkg::BIT_HOLD_ERR] = events.hold_err & holding_state; // see [R7]
      set_vec[ssw_pkg::BIT_MOVE_ERR] = events.move_err & moving_state; // see [R8]
      set_vec[ssw_pkg::BIT_INDEX] = events.index_found; // see [R12]
   end

   // Clear terms: the clear command hits all latched bits, a move start bit 11
   wire [15:0] clr_vec = ({16{cmd.clear_latched_status_cmd}} & ssw_pkg::LATCHED_BITS) // see [R13]
      | (move_start ? (16'h0001 << ssw_pkg::BIT_INPUT_FOUND) : 16'h0000); // see [R5]

   // Set wins over clear; only latched positions are kept
   always_comb begin
      next_latched = ((latched & ~clr_vec) | set_vec) & ssw_pkg::LATCHED_BITS; // see [R14]
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         latched <= ssw_pkg::STATUS_RESET;
      end else begin
         latched <= next_latched;
      end
   end

   // ----------------------------------------
   // Assembled word
   // ----------------------------------------
   logic [15:0] live_vec;

   // Live bits follow present conditions
   always_comb begin
      live_vec = '0;
      live_vec[ssw_pkg::BIT_TEMP_OK] = ~sync_over_temp; // see [R9]
      live_vec[ssw_pkg::BIT_IO3] = sync_io[2]; // see [R10]
      live_vec[ssw_pkg::BIT_IO2] = sync_io[1]; // see [R10]
      live_vec[ssw_pkg::BIT_IO1] = sync_io[0]; // see [R10]
      live_vec[ssw_pkg::BIT_CALC_NEG] = live.calc_neg; // see [R11]
      live_vec[ssw_pkg::BIT_CALC_POS] = live.calc_pos; // see [R11]
      live_vec[ssw_pkg::BIT_CALC_ZERO] = live.calc_zero; // see [R11]
   end

   // Reserved bit forced low
   wire [15:0] word_now = (latched | live_vec) & ~(16'h0001 << ssw_pkg::BIT_RESERVED); // see [R19]

   // ----------------------------------------
   // Condition mask and poll bit
   // ----------------------------------------
   logic [14:0] mask;
   wire [14:0] next_mask = mask ^ mask_toggle; // see [R16]
   wire poll_now = |(word_now[14:0] & mask); // see [R17]

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         mask <= ssw_pkg::MASK_RESET;
      end else if (cmd.status_check_mask_cmd) begin
         mask <= next_mask; // see [R16]
      end
   end

   // ----------------------------------------
   // Register and stop outputs
   // ----------------------------------------
   wire reg_hit = (reg_addr == ssw_pkg::MOTION_STATUS_FLAGS_REG);
   wire stop_now = |(word_now & stop_select); // see [R18]

   // Registered outputs
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_word <= ssw_pkg::STATUS_RESET;
         check_mask <= ssw_pkg::MASK_RESET;
         poll_status_bit <= 1'b0;
         reg_rdata <= '0;
         stop_hit <= 1'b0;
      end else begin
         status_word <= word_now;
         check_mask <= mask;
         poll_status_bit <= poll_now; // see [R17]
         reg_rdata <= reg_hit ? {word_now, 16'h0000} : 32'h0000_0000; // see [R1]
         stop_hit <= stop_now; // see [R18]
      end
   end

   // ----------------------------------------
   // Decimal answer to the read command
   // ----------------------------------------
   logic conv_done;
   logic [19:0] conv_bcd;

   ssw_bcd_conv #(
      .WIDTH(16),
      .DIGITS(ssw_pkg::BCD_DIGITS)
   ) u_bcd (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .start(cmd.read_status_cmd), // see [R15]
      .value(word_now),
      .busy(),
      .done(conv_done),
      .bcd(conv_bcd)
   );

   // Answer held until the next answer
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         answer_valid <= 1'b0;
         answer_decimal <= '0;
      end else begin
         answer_valid <= conv_done;
         if (conv_done) begin
            answer_decimal <= conv_bcd; // see [R15]
         end
      end
   end
endmodule // ssw_status_word

// ---- tb/ssw_status_word_assertions.sv ----
// Checker for the servo status word flags block
`timescale 1ns/1ps
module ssw_chk (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // Watched ports
   input wire ssw_pkg::ssw_events_t events,
   input wire logic move_start,
   input wire logic holding_state,
   input wire logic moving_state,
   input wire ssw_pkg::ssw_cmd_t cmd,
   input wire logic [14:0] mask_toggle,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_rdata,
   input wire logic [15:0] status_word,
   input wire logic [14:0] check_mask,
   input wire logic poll_status_bit,
   input wire logic answer_valid
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   a_halt_latch:
   assert property (events.halt_seen |-> ##2 status_word[10]) else $error("halt flag lost");
   a_move_err:
   assert property (events.move_err && moving_state |-> ##2 status_word[8])
      else $error("moving error flag lost");
   a_hold_err:
   assert property (events.hold_err && holding_state |-> ##2 status_word[9])
      else $error("holding error flag lost");
   a_index_latch:
   assert property (events.index_found |-> ##2 status_word[0]) else $error("index flag lost");
   a_move_clear:
   assert property (move_start && !events.input_found |-> ##2 !status_word[11])
      else $error("input found flag not cleared by move");
   a_clear_wipe:
   assert property (cmd.clear_latched_status_cmd && events == '0 |->
      ##2 (status_word & ssw_pkg::LATCHED_BITS) == 16'h0000) else $error("clear missed");
   a_reserved_zero:
   assert property (status_word[15] == 1'b0) else $error("reserved bit set");
   a_poll_or:
   assert property (poll_status_bit == |(status_word[14:0] & check_mask))
      else $error("poll bit wrong");
   a_mask_toggle:
   assert property (cmd.status_check_mask_cmd |->
      ##2 check_mask == ($past(check_mask, 1) ^ $past(mask_toggle, 2))) else $error("mask wrong");
   a_reg_word:
   assert property (reg_addr == 8'h03 |=> reg_rdata == {status_word, 16'h0000})
      else $error("register 3 wrong");
   a_answer_time:
   assert property (answer_valid |-> $past(cmd.read_status_cmd, 18) ##1 !answer_valid)
      else $error("answer timing wrong");
endmodule // ssw_chk

// ---- tb/ssw_host_model.sv ----
// Host model issuing status commands to the block
`timescale 1ns/1ps
module ssw_host (
   // Clock
   input wire logic ref_clk,
   // Command strobes and toggle selector
   output ssw_pkg::ssw_cmd_t cmd,
   output logic [14:0] mask_toggle
);
   // Idle strobes
   initial begin
      cmd = '0;
      mask_toggle = 15'h0000;
   end
   // One-cycle strobe, selector inverted once released
   task send(input ssw_pkg::ssw_cmd_t c, input logic [14:0] t);
      @(posedge ref_clk);
      #1 cmd = c;
      mask_toggle = t;
      @(posedge ref_clk);
      #1 cmd = '0;
      mask_toggle = ~t;
   endtask
endmodule // ssw_host

// ---- tb/tb_servo_status_word_flags.sv ----
// Testbench for the servo status word flags block
`timescale 1ns/1ps
module tb_servo_status_word_flags;
   logic ref_clk, rst_n, move_start, holding_state, moving_state, stop_hit;
   logic poll_status_bit, answer_valid;
   ssw_pkg::ssw_events_t events;
   ssw_pkg::ssw_live_t live;
   ssw_pkg::ssw_cmd_t cmd;
   logic [14:0] mask_toggle, check_mask;
   logic [7:0] reg_addr;
   logic [31:0] reg_rdata;
   logic [15:0] stop_select, status_word;
   logic [19:0] answer_decimal;
   int miscompares = 0;
   int checked = 0;
   // 250 MHz clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end
   ssw_status_word dut (.ref_clk(ref_clk), .rst_n(rst_n), .events(events), .live(live),
      .move_start(move_start), .holding_state(holding_state), .moving_state(moving_state),
      .cmd(cmd), .mask_toggle(mask_toggle), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
      .stop_select(stop_select), .stop_hit(stop_hit), .status_word(status_word),
      .check_mask(check_mask), .poll_status_bit(poll_status_bit),
      .answer_valid(answer_valid), .answer_decimal(answer_decimal));
   ssw_host host (.ref_clk(ref_clk), .cmd(cmd), .mask_toggle(mask_toggle));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s exp %h got %h", name, exp, got);
      end
   endtask
   task stop_test;
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Event pulse, struct bit b, word shows it two edges on
   task pulse_ev(input int b);
      events = ssw_pkg::ssw_events_t'(8'h01 << b);
      cyc(1);
      events = '0;
      cyc(2);
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_events;
      pulse_ev(2);
      pulse_ev(1);
      chk("gated errors", 32'h0000_00F0, 32'(status_word));
      holding_state = 1'b1;
      moving_state = 1'b1;
      for (int b = 0; b < 8; b++) begin
         pulse_ev(b);
         chk("latched", 32'h1, 32'(status_word[b == 0 ? 0 : b + 7]));
      end
      host.send(3'h2, 15'h0000);
      cyc(2);
      chk("cleared", 32'h0000_00F0, 32'(status_word));
   endtask
   task t_move;
      pulse_ev(3);
      pulse_ev(4);
      move_start = 1'b1;
      cyc(1);
      move_start = 1'b0;
      cyc(2);
      chk("next move", 32'h0000_04F0, 32'(status_word));
   endtask
   task t_read_reg;
      int i;
      host.send(3'h4, 15'h0000);
      for (i = 0; i < 30 && answer_valid !== 1'b1; i++) cyc(1);
      if (i == 30) begin
         miscompares++;
         stop_test;
      end
      chk("decimal", 32'h0000_1264, 32'(answer_decimal));
      reg_addr = 8'h03;
      cyc(1);
      chk("reg 3", 32'h04F0_0000, reg_rdata);
      reg_addr = 8'h04;
      cyc(1);
      chk("reg 4", 32'h0000_0000, reg_rdata);
   endtask
   task t_mask_stop;
      host.send(3'h1, 15'h0400);
      cyc(2);
      chk("mask", 32'h0000_0400, 32'(check_mask));
      chk("poll on", 32'h1, 32'(poll_status_bit));
      host.send(3'h1, 15'h0401);
      cyc(2);
      chk("poll off", 32'h0, 32'(poll_status_bit));
      stop_select = 16'h0400;
      cyc(2);
      chk("stop on", 32'h1, 32'(stop_hit));
      stop_select = 16'h0100;
      cyc(2);
      chk("stop off", 32'h0, 32'(stop_hit));
   endtask
   task t_live;
      live.io_line = 3'h2;
      live.over_temp = 1'b1;
      live.calc_neg = 1'b1;
      cyc(5);
      chk("live", 32'h0000_0428, 32'(status_word));
   endtask
   // Main sequence
   initial begin
      rst_n = 1'b0;
      events = '0;
      live = '0;
      live.io_line = 3'h7;
      move_start = 1'b0;
      holding_state = 1'b0;
      moving_state = 1'b0;
      reg_addr = 8'h00;
      stop_select = 16'h0000;
      repeat (3) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      cyc(2);
      chk("reset word", 32'h0000_00F0, 32'(status_word));
      t_events;
      t_move;
      t_read_reg;
      t_mask_stop;
      t_live;
      stop_test;
   end
endmodule // tb_servo_status_word_flags
bind ssw_status_word ssw_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .events(events),
   .move_start(move_start), .holding_state(holding_state), .moving_state(moving_state), .cmd(cmd),
   .mask_toggle(mask_toggle), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
   .status_word(status_word), .check_mask(check_mask),
   .poll_status_bit(poll_status_bit), .answer_valid(answer_valid));
